// [verilog/fis_pkg.sv]
`default_nettype none
package fis_pkg;
	// ----------------------------------------------------------------
	// array geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W     = 12;
	localparam int DATA_W     = 16;
	localparam int PAGE_W     = 5;
	localparam int PAGE_WORDS = 32;
	localparam int TMR_W      = 24;
	localparam logic [PAGE_W-1:0] PAGE_LAST = 5'h1f;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_CTRL2 = 8'h08;
	localparam logic [7:0] OFS_ADRL  = 8'h0c;
	localparam logic [7:0] OFS_ADRH  = 8'h10;
	localparam logic [7:0] OFS_D0L   = 8'h14;
	localparam logic [7:0] OFS_D0H   = 8'h18;
	localparam logic [7:0] OFS_K1L   = 8'h1c;
	localparam logic [7:0] OFS_K1H   = 8'h20;
	localparam logic [7:0] OFS_K2L   = 8'h24;
	localparam logic [7:0] OFS_K2H   = 8'h28;
	localparam logic [7:0] OFS_K3L   = 8'h2c;
	localparam logic [7:0] OFS_K3H   = 8'h30;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int C0_OPSEL   = 0;
	localparam int C0_PERMIT  = 3;
	localparam int C0_ARM     = 4;
	localparam int C0_UNLOCK  = 5;
	localparam int C1_FETCH   = 0;
	localparam int C1_PROG    = 1;
	localparam int C1_CLEAR   = 2;
	localparam int C1_BUSY    = 3;
	localparam int C2_TSEL    = 0;
	localparam int ADRH_W     = 4;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// operation codes and unlock key
	// ----------------------------------------------------------------
	localparam logic [2:0] OP_WRITE  = 3'h0;
	localparam logic [2:0] OP_ERASE  = 3'h1;
	localparam logic [2:0] OP_READ   = 3'h3;
	localparam logic [2:0] OP_UNLOCK = 3'h6;
	localparam logic [23:0] KEY_LOW  = 24'hc30d00;
	localparam logic [23:0] KEY_HIGH = 24'h400904;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 10;
	localparam int PROG_SHORT_US     = 2000;
	localparam int PROG_LONG_US      = 4000;
	localparam int UNLOCK_WINDOW_US  = 100;
	localparam int INSTR_CLKS        = 4;
	localparam int FETCH_INSTR       = 3;
	localparam int PROG_SHORT_CYC    = PROG_SHORT_US * 1000 / CLK_PERIOD_NS;
	localparam int PROG_LONG_CYC     = PROG_LONG_US * 1000 / CLK_PERIOD_NS;
	localparam int UNLOCK_CYC        = UNLOCK_WINDOW_US * 1000 / CLK_PERIOD_NS;
	localparam int FETCH_CYC         = FETCH_INSTR * INSTR_CLKS;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_FETCH} fis_state_t;

	typedef struct packed {
		logic              erase;
		logic              prog;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} fis_flash_req_t;
endpackage : fis_pkg
`default_nettype wire

// [verilog/fis_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module fis_timer
	import fis_pkg::*;
(
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// control
	input  wire logic             load,
	input  wire logic [TMR_W-1:0] load_val,
	// status
	output logic                  running,
	output logic                  done
);
	logic [TMR_W-1:0] cnt_reg;
	logic [TMR_W-1:0] cnt_next;

	always_comb begin
		cnt_next = cnt_reg;
		if (load) begin
			cnt_next = load_val;
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - TMR_W'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign running = (cnt_reg != '0);
	assign done    = (cnt_reg == TMR_W'(1)) && !load;
endmodule : fis_timer
`default_nettype wire

// [verilog/fis_wbuf.sv]
`timescale 1ns/1ns
`default_nettype none
module fis_wbuf
	import fis_pkg::*;
(
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// fill side
	input  wire logic              clr,
	input  wire logic              we,
	input  wire logic [PAGE_W-1:0] widx,
	input  wire logic [DATA_W-1:0] wdata,
	// drain side
	input  wire logic [PAGE_W-1:0] ridx,
	output logic      [DATA_W-1:0] rdata,
	output logic                   rtag
);
	logic [DATA_W-1:0]     mem_reg [PAGE_WORDS];
	logic [DATA_W-1:0]     mem_next [PAGE_WORDS];
	logic [PAGE_WORDS-1:0] tag_reg;
	logic [PAGE_WORDS-1:0] tag_next;

	// ----------------------------------------------------------------
	// per-entry next state
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < PAGE_WORDS; i++) begin : g_ent
			always_comb begin
				mem_next[i] = mem_reg[i];
				tag_next[i] = tag_reg[i] && !clr;
				if (we && (widx == PAGE_W'(i))) begin
					mem_next[i] = wdata;
					tag_next[i] = 1'b1;
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					mem_reg[i] <= '0;
					tag_reg[i] <= 1'b0;
				end else begin
					mem_reg[i] <= mem_next[i];
					tag_reg[i] <= tag_next[i];
				end
			end
		end
	endgenerate

	assign rdata = mem_reg[ridx];
	assign rtag  = tag_reg[ridx];
endmodule : fis_wbuf
`default_nettype wire

// [verilog/fis_top.sv]
// Overview of operation
// R1: operation select 001 is erase mode.
// R2: writing buffer clear high empties the whole page write buffer.
// R3: erase trigger erases the whole addressed page, never part of it.
// R4: hardware clears program trigger at end; software polls it low.
// R5: operation select 000 is write mode.
// R6: buffer holds 32 sixteen-bit words; software loads no more.
// R7: write trigger programs whole buffer into page of upper address bits; code programs only words loaded since last clear.
// R8: CPU stalls while erase, write or read runs.
// R9: program trigger high time set by time select bit.
// R10: erase and write only after unlock sets the unlocked flag.
// R11: software keeps buffered addresses within one page.
// R12: rewrite of the same page allowed without a new erase.
// R13: clearing unlocked flag refuses further erase and write.
// R14: read needs select 011 and fetch permit; no unlock needed.
// R15: fetch trigger loads word into data word 0; self clears.
// R16: fetch trigger falls about three instruction cycles after set.
// R17: non-consecutive words each need own address, load and trigger.
// R18: software blank-checks after erase, repeats if it fails.
// R19: software runs at top clock rate for writes and verify.
// R20: 110 plus unlock arm starts window; arm self clears at expiry.
// R21: only correct key in window sets unlocked flag.
// R22: high data byte write loads buffer and bumps address.
// R23: address bump stops at page last word 11111b.
// R24: triggers with wrong mode or locked state are ignored.
`timescale 1ns/1ns
`default_nettype none
module fis_top
	import fis_pkg::*;
#(
	parameter int PROG_CYC_SHORT = PROG_SHORT_CYC,
	parameter int PROG_CYC_LONG  = PROG_LONG_CYC,
	parameter int UNLOCK_WIN_CYC = UNLOCK_CYC,
	parameter int FETCH_WAIT_CYC = FETCH_CYC
) (
	// clock and reset
	input  wire logic           hclk,
	input  wire logic           hresetn,
	// ahb-lite slave
	input  wire logic           hsel,
	input  wire logic [31:0]    haddr,
	input  wire logic [1:0]     htrans,
	input  wire logic           hwrite,
	input  wire logic [2:0]     hsize,
	input  wire logic [31:0]    hwdata,
	input  wire logic           hready,
	output logic                hreadyout,
	output logic      [31:0]    hrdata,
	output logic                hresp,
	// flash array
	output fis_flash_req_t      flash_req,
	input  wire logic [DATA_W-1:0] flash_rdata,
	// cpu
	output logic                cpu_stall
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (PROG_CYC_SHORT <= PAGE_WORDS || PROG_CYC_LONG <= PAGE_WORDS ||
	    PROG_CYC_SHORT >= 2**TMR_W || PROG_CYC_LONG >= 2**TMR_W ||
	    UNLOCK_WIN_CYC < 1 || UNLOCK_WIN_CYC >= 2**TMR_W ||
	    FETCH_WAIT_CYC < 2 || FETCH_WAIT_CYC >= 2**TMR_W) begin : g_chk
		$error("fis_top: timing parameter out of range");
	end

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic        take;
	logic        wr_pend_reg, wr_pend_next;
	logic        rd_pend_reg, rd_pend_next;
	logic [7:0]  dp_addr_reg, dp_addr_next;
	logic        hreadyout_reg, hreadyout_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [31:0] rd_mux;
	logic [7:0]  wd;

	assign take = hsel && htrans[1] && hready;
	assign wd   = hwdata[7:0];

	always_comb begin
		wr_pend_next   = take && hwrite;
		rd_pend_next   = take && !hwrite;
		dp_addr_next   = take ? haddr[7:0] : dp_addr_reg;
		hreadyout_next = !(take && !hwrite);
		hrdata_next    = rd_pend_reg ? rd_mux : 32'h0000_0000;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg   <= 1'b0;
			rd_pend_reg   <= 1'b0;
			dp_addr_reg   <= RST_BYTE;
			hreadyout_reg <= 1'b1;
			hrdata_reg    <= 32'h0000_0000;
		end else begin
			wr_pend_reg   <= wr_pend_next;
			rd_pend_reg   <= rd_pend_next;
			dp_addr_reg   <= dp_addr_next;
			hreadyout_reg <= hreadyout_next;
			hrdata_reg    <= hrdata_next;
		end
	end

	assign hreadyout = hreadyout_reg;
	assign hrdata    = hrdata_reg;
	assign hresp     = 1'b0;

	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	fis_state_t        state_reg, state_next;
	logic [2:0]        opsel_reg, opsel_next;
	logic              permit_reg, permit_next;
	logic              arm_reg, arm_next;
	logic              unlocked_reg, unlocked_next;
	logic              tsel_reg, tsel_next;
	logic              prog_trig_reg, prog_trig_next;
	logic              fetch_trig_reg, fetch_trig_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [7:0]        d0l_reg, d0l_next;
	logic [7:0]        d0h_reg, d0h_next;
	logic [23:0]       keyl_reg, keyl_next;
	logic [23:0]       keyh_reg, keyh_next;
	logic [PAGE_W:0]   walk_reg, walk_next;
	fis_flash_req_t    freq_reg, freq_next;
	logic              stall_reg, stall_next;

	logic              buf_clr, buf_we, buf_rtag;
	logic [DATA_W-1:0] buf_rdata;
	logic              op_load, op_done, arm_load, arm_done;
	logic [TMR_W-1:0]  op_val;

	fis_wbuf u_wbuf (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clr     (buf_clr),
		.we      (buf_we),
		.widx    (addr_reg[PAGE_W-1:0]),
		.wdata   ({wd, d0l_reg}),
		.ridx    (walk_reg[PAGE_W-1:0]),
		.rdata   (buf_rdata),
		.rtag    (buf_rtag)
	);

	fis_timer u_op_tmr (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.load     (op_load),
		.load_val (op_val),
		.running  (),
		.done     (op_done)
	);

	fis_timer u_arm_tmr (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.load     (arm_load),
		.load_val (TMR_W'(UNLOCK_WIN_CYC)),
		.running  (),
		.done     (arm_done)
	);

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (dp_addr_reg)
			OFS_CTRL0: rd_mux[7:0] = {2'b00, unlocked_reg, arm_reg, permit_reg, opsel_reg};
			OFS_CTRL1: rd_mux[7:0] = {4'h0, (state_reg != ST_IDLE), 1'b0, prog_trig_reg, fetch_trig_reg};
			OFS_CTRL2: rd_mux[C2_TSEL] = tsel_reg;
			OFS_ADRL:  rd_mux[7:0] = addr_reg[7:0];
			OFS_ADRH:  rd_mux[ADRH_W-1:0] = addr_reg[ADDR_W-1:8];
			OFS_D0L:   rd_mux[7:0] = d0l_reg;
			OFS_D0H:   rd_mux[7:0] = d0h_reg;
			OFS_K1L:   rd_mux[7:0] = keyl_reg[7:0];
			OFS_K1H:   rd_mux[7:0] = keyh_reg[7:0];
			OFS_K2L:   rd_mux[7:0] = keyl_reg[15:8];
			OFS_K2H:   rd_mux[7:0] = keyh_reg[15:8];
			OFS_K3L:   rd_mux[7:0] = keyl_reg[23:16];
			OFS_K3H:   rd_mux[7:0] = keyh_reg[23:16];
			default:   rd_mux = 32'h0000_0000;
		endcase
	end

	always_comb begin
		state_next      = state_reg;
		opsel_next      = opsel_reg;
		permit_next     = permit_reg;
		arm_next        = arm_reg;
		unlocked_next   = unlocked_reg;
		tsel_next       = tsel_reg;
		prog_trig_next  = prog_trig_reg;
		fetch_trig_next = fetch_trig_reg;
		addr_next       = addr_reg;
		d0l_next        = d0l_reg;
		d0h_next        = d0h_reg;
		keyl_next       = keyl_reg;
		keyh_next       = keyh_reg;
		walk_next       = walk_reg;
		freq_next       = '0;
		freq_next.addr  = freq_reg.addr;
		freq_next.wdata = freq_reg.wdata;
		buf_clr         = 1'b0;
		buf_we          = 1'b0;
		op_load         = 1'b0;
		op_val          = tsel_reg ? TMR_W'(PROG_CYC_LONG) : TMR_W'(PROG_CYC_SHORT); // [R9]
		arm_load        = 1'b0;

		// software writes
		if (wr_pend_reg) begin
			case (dp_addr_reg)
				OFS_CTRL0: begin
					opsel_next  = wd[C0_OPSEL +: 3];
					permit_next = wd[C0_PERMIT];
					if (wd[C0_ARM] && (wd[C0_OPSEL +: 3] == OP_UNLOCK) && !arm_reg) begin
						arm_next = 1'b1; // [R20]
						arm_load = 1'b1; // [R20]
					end
					if (!wd[C0_UNLOCK]) begin
						unlocked_next = 1'b0; // [R13]
					end
				end
				OFS_CTRL1: begin
					if (wd[C1_CLEAR]) begin
						buf_clr = 1'b1; // [R2]
					end
					if (state_reg == ST_IDLE) begin
						if (wd[C1_PROG] && unlocked_reg && (opsel_reg == OP_ERASE)) begin // [R1] [R10] [R24]
							state_next      = ST_ERASE; // [R3]
							prog_trig_next  = 1'b1;
							op_load         = 1'b1;
							freq_next.erase = 1'b1;
							freq_next.addr  = {addr_reg[ADDR_W-1:PAGE_W], PAGE_W'(0)}; // [R3]
						end else if (wd[C1_PROG] && unlocked_reg && (opsel_reg == OP_WRITE)) begin // [R5] [R10] [R24]
							state_next     = ST_PROG; // [R12]
							prog_trig_next = 1'b1;
							op_load        = 1'b1;
							walk_next      = '0;
						end else if (wd[C1_FETCH] && permit_reg && (opsel_reg == OP_READ)) begin // [R14] [R24]
							state_next      = ST_FETCH;
							fetch_trig_next = 1'b1;
							op_load         = 1'b1;
							op_val          = TMR_W'(FETCH_WAIT_CYC); // [R16]
							freq_next.rd    = 1'b1;
							freq_next.addr  = addr_reg;
						end
					end
				end
				OFS_CTRL2: tsel_next = wd[C2_TSEL];
				OFS_ADRL:  addr_next[7:0] = wd;
				OFS_ADRH:  addr_next[ADDR_W-1:8] = wd[ADRH_W-1:0];
				OFS_D0L:   d0l_next = wd;
				OFS_D0H: begin
					d0h_next = wd;
					buf_we   = 1'b1; // [R22] [R6]
					if (addr_reg[PAGE_W-1:0] != PAGE_LAST) begin
						addr_next = addr_reg + ADDR_W'(1); // [R22] [R23]
					end
				end
				OFS_K1L:   keyl_next[7:0]   = wd;
				OFS_K1H:   keyh_next[7:0]   = wd;
				OFS_K2L:   keyl_next[15:8]  = wd;
				OFS_K2H:   keyh_next[15:8]  = wd;
				OFS_K3L:   keyl_next[23:16] = wd;
				OFS_K3H:   keyh_next[23:16] = wd;
				default: ;
			endcase
		end

		// unlock window
		if (arm_done) begin
			arm_next = 1'b0; // [R20]
		end
		if (arm_reg && (keyl_reg == KEY_LOW) && (keyh_reg == KEY_HIGH)) begin
			unlocked_next = 1'b1; // [R21]
		end

		// operations in progress
		case (state_reg)
			ST_IDLE: ;
			ST_ERASE: begin
				freq_next.erase = !op_done; // [R3] [R4]
				if (op_done) begin
					state_next     = ST_IDLE;
					prog_trig_next = 1'b0; // [R4]
				end
			end
			ST_PROG: begin
				if (walk_reg < (PAGE_W+1)'(PAGE_WORDS)) begin
					walk_next = walk_reg + (PAGE_W+1)'(1); // [R7]
					if (buf_rtag) begin
						freq_next.prog  = 1'b1; // [R7]
						freq_next.addr  = {addr_reg[ADDR_W-1:PAGE_W], walk_reg[PAGE_W-1:0]};
						freq_next.wdata = buf_rdata;
					end
				end
				if (op_done) begin
					state_next     = ST_IDLE;
					prog_trig_next = 1'b0; // [R4]
				end
			end
			ST_FETCH: begin
				if (op_done) begin
					state_next      = ST_IDLE;
					fetch_trig_next = 1'b0; // [R15]
					d0l_next        = flash_rdata[7:0]; // [R15]
					d0h_next        = flash_rdata[DATA_W-1:8];
				end
			end
			default: state_next = ST_IDLE;
		endcase

		stall_next = (state_next != ST_IDLE); // [R8]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg      <= ST_IDLE;
			opsel_reg      <= OP_WRITE;
			permit_reg     <= 1'b0;
			arm_reg        <= 1'b0;
			unlocked_reg   <= 1'b0;
			tsel_reg       <= 1'b0;
			prog_trig_reg  <= 1'b0;
			fetch_trig_reg <= 1'b0;
			addr_reg       <= '0;
			d0l_reg        <= RST_BYTE;
			d0h_reg        <= RST_BYTE;
			keyl_reg       <= '0;
			keyh_reg       <= '0;
			walk_reg       <= '0;
			freq_reg       <= '0;
			stall_reg      <= 1'b0;
		end else begin
			state_reg      <= state_next;
			opsel_reg      <= opsel_next;
			permit_reg     <= permit_next;
			arm_reg        <= arm_next;
			unlocked_reg   <= unlocked_next;
			tsel_reg       <= tsel_next;
			prog_trig_reg  <= prog_trig_next;
			fetch_trig_reg <= fetch_trig_next;
			addr_reg       <= addr_next;
			d0l_reg        <= d0l_next;
			d0h_reg        <= d0h_next;
			keyl_reg       <= keyl_next;
			keyh_reg       <= keyh_next;
			walk_reg       <= walk_next;
			freq_reg       <= freq_next;
			stall_reg      <= stall_next;
		end
	end

	assign flash_req = freq_reg;
	assign cpu_stall = stall_reg;
endmodule : fis_top
`default_nettype wire

// [verif/fis_top_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module fis_top_checker
	import fis_pkg::*;
#(
	parameter int PROG_CYC_SHORT = PROG_SHORT_CYC,
	parameter int PROG_CYC_LONG  = PROG_LONG_CYC,
	parameter int UNLOCK_WIN_CYC = UNLOCK_CYC,
	parameter int FETCH_WAIT_CYC = FETCH_CYC
) (
	// clock and reset
	input wire logic              hclk,
	input wire logic              hresetn,
	// ahb-lite
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic [2:0]        hsize,
	input wire logic [31:0]       hwdata,
	input wire logic              hready,
	input wire logic              hreadyout,
	input wire logic [31:0]       hrdata,
	input wire logic              hresp,
	// flash and cpu
	input wire fis_flash_req_t    flash_req,
	input wire logic [DATA_W-1:0] flash_rdata,
	input wire logic              cpu_stall
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ----
	// stall length counter
	// ----
	logic [TMR_W-1:0] stall_reg;
	logic [TMR_W-1:0] stall_next;
	logic             take;
	assign take = hsel && htrans[1] && hready;
	always_comb begin
		stall_next = cpu_stall ? stall_reg + 1'b1 : '0;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) stall_reg <= '0;
		else stall_reg <= stall_next;
	end

	// ----
	// properties
	// ----
	property p_rd_wait;
		take && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	property p_wr_nowait;
		take && hwrite |=> hreadyout;
	endproperty
	property p_erase_base;
		flash_req.erase |-> flash_req.addr[PAGE_W-1:0] == '0;
	endproperty
	property p_erase_stall;
		flash_req.erase |-> cpu_stall;
	endproperty
	property p_prog_stall;
		flash_req.prog |-> cpu_stall && !flash_req.erase;
	endproperty
	property p_rd_pulse;
		flash_req.rd |-> cpu_stall ##1 !flash_req.rd;
	endproperty
	property p_stall_len;
		$fell(cpu_stall) |-> stall_reg == FETCH_WAIT_CYC || stall_reg == PROG_CYC_SHORT || stall_reg == PROG_CYC_LONG;
	endproperty
	property p_erase_end;
		$fell(flash_req.erase) |-> $fell(cpu_stall);
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read data phase not one wait");
	a_wr_nowait: assert property (p_wr_nowait) else $error("write data phase stalled");
	a_erase_base: assert property (p_erase_base) else $error("erase address not page base");
	a_erase_stall: assert property (p_erase_stall) else $error("erase without cpu stall");
	a_prog_stall: assert property (p_prog_stall) else $error("program without stall");
	a_rd_pulse: assert property (p_rd_pulse) else $error("read request not a stalled pulse");
	a_stall_len: assert property (p_stall_len) else $error("operation length wrong");
	a_erase_end: assert property (p_erase_end) else $error("erase and stall end apart");
	c_erase: cover property (flash_req.erase);
	c_prog: cover property (flash_req.prog);
	c_rd: cover property (flash_req.rd);
	c_rd_wait: cover property (take && !hwrite);
endmodule : fis_top_checker

bind fis_top fis_top_checker #(
	.PROG_CYC_SHORT(PROG_CYC_SHORT), .PROG_CYC_LONG(PROG_CYC_LONG),
	.UNLOCK_WIN_CYC(UNLOCK_WIN_CYC), .FETCH_WAIT_CYC(FETCH_WAIT_CYC)
) u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.hresp(hresp), .flash_req(flash_req), .flash_rdata(flash_rdata), .cpu_stall(cpu_stall)
);
`default_nettype wire

// [verif/fis_flash_model.sv]
`timescale 1ns/1ns
`default_nettype none
module fis_flash_model
	import fis_pkg::*;
#(
	parameter int HOLD_CYC = FETCH_CYC
) (
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// array port
	input  wire fis_flash_req_t    flash_req,
	output logic      [DATA_W-1:0] flash_rdata
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	int                hold;
	int                erase_cnt = 0;
	int                prog_cnt  = 0;
	int                rd_cnt    = 0;
	logic              erase_q;
	initial begin
		for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = 16'(i) ^ 16'h5a5a;
	end
	// read data held for the fetch, then scrambled every cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flash_rdata <= '0;
			hold <= 0;
			erase_q <= 1'b0;
		end else begin
			erase_q <= flash_req.erase;
			if (flash_req.erase) begin
				for (int i = 0; i < PAGE_WORDS; i++) mem[{flash_req.addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= '0;
				if (!erase_q) erase_cnt <= erase_cnt + 1;
			end
			if (flash_req.prog) begin
				mem[flash_req.addr] <= flash_req.wdata;
				prog_cnt <= prog_cnt + 1;
			end
			if (flash_req.rd) begin
				flash_rdata <= mem[flash_req.addr];
				hold <= HOLD_CYC;
				rd_cnt <= rd_cnt + 1;
			end else if (hold > 0) hold <= hold - 1;
			else flash_rdata <= ~flash_rdata;
		end
	end
endmodule : fis_flash_model
`default_nettype wire

// [verif/fis_top_test.sv]
`timescale 1ns/1ns
`default_nettype none
module fis_top_test
	import fis_pkg::*;
;
	localparam int PS = 40;
	localparam int PL = 50;
	localparam int UW = 30;
	localparam int FW = 4;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_stall;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	fis_flash_req_t flash_req;
	logic [DATA_W-1:0] flash_rdata;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;

	fis_top #(.PROG_CYC_SHORT(PS), .PROG_CYC_LONG(PL), .UNLOCK_WIN_CYC(UW), .FETCH_WAIT_CYC(FW)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .flash_req(flash_req), .flash_rdata(flash_rdata), .cpu_stall(cpu_stall));
	fis_flash_model #(.HOLD_CYC(FW)) model (.hclk(hclk), .hresetn(hresetn), .flash_req(flash_req),
		.flash_rdata(flash_rdata));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) cyc <= cyc + 1;

	// ----
	// bus and compare tasks
	// ----
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rv);
		haddr <= {24'h0, ofs};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		logic [31:0] x;
		bus(1'b1, ofs, {24'h0, d}, x);
	endtask : wr
	task automatic rdc(input string what, input logic [7:0] ofs, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, ofs, 32'h0, x);
		chk(what, exp, x);
		chk("response", 32'h0, {31'h0, hresp});
	endtask : rdc
	task automatic poll(input logic [7:0] msk, output int el);
		logic [31:0] x;
		int t0;
		t0 = cyc;
		x = {24'h0, msk};
		while ((x[7:0] & msk) != 8'h0) bus(1'b0, OFS_CTRL1, 32'h0, x);
		el = cyc - t0;
	endtask : poll

	// ----
	// scenarios
	// ----
	task automatic t_reset;
		rdc("ctrl0", OFS_CTRL0, 32'h0);
		rdc("ctrl1", OFS_CTRL1, 32'h0);
		wr(8'h3c, 8'hff);
		rdc("unmapped", 8'h3c, 32'h0);
		wr(OFS_CTRL0, 8'h01);
		wr(OFS_CTRL1, 8'h02);
		rdc("trigger while locked", OFS_CTRL1, 32'h0);
		chk("erase count", 32'h0, model.erase_cnt);
		$display("test reset and lock done");
	endtask : t_reset
	task automatic unlock(input logic [7:0] k3h, input logic [7:0] flag);
		wr(OFS_CTRL0, 8'h16);
		wr(OFS_K1L, 8'h00);
		wr(OFS_K2L, 8'h0d);
		wr(OFS_K3L, 8'hc3);
		wr(OFS_K1H, 8'h04);
		wr(OFS_K2H, 8'h09);
		wr(OFS_K3H, k3h);
		rdc("armed flag", OFS_CTRL0, {24'h0, flag | 8'h16});
		repeat (UW) @(posedge hclk);
		rdc("arm expired", OFS_CTRL0, {24'h0, flag | 8'h06});
		$display("test unlock done");
	endtask : unlock
	task automatic t_erase(input logic [7:0] tsel, input int p);
		int el;
		wr(OFS_CTRL2, tsel);
		wr(OFS_CTRL0, 8'h21);
		wr(OFS_ADRL, 8'h45);
		wr(OFS_ADRH, 8'h03);
		wr(OFS_CTRL1, 8'h04);
		wr(OFS_D0H, 8'h00);
		wr(OFS_CTRL1, 8'h02);
		poll(8'h02, el);
		chk("erase time", 32'h1, {31'h0, el >= p && el <= p + 6});
		chk("page first", 32'h0, {16'h0, model.mem[12'h340]});
		chk("page last", 32'h0, {16'h0, model.mem[12'h35f]});
		chk("next page", {16'h0, 16'h0360 ^ 16'h5a5a}, {16'h0, model.mem[12'h360]});
		$display("test erase done");
	endtask : t_erase
	task automatic t_write;
		int el;
		wr(OFS_CTRL0, 8'h20);
		wr(OFS_CTRL1, 8'h04);
		wr(OFS_ADRL, 8'h5e);
		for (logic [7:0] i = 0; i < 8'h3; i++) begin
			wr(OFS_D0L, 8'h10 + i);
			wr(OFS_D0H, 8'ha0 + i);
		end
		rdc("address at page end", OFS_ADRL, 32'h5f);
		wr(OFS_CTRL1, 8'h02);
		poll(8'h02, el);
		chk("word 30", 32'ha010, {16'h0, model.mem[12'h35e]});
		chk("word 31", 32'ha212, {16'h0, model.mem[12'h35f]});
		chk("untagged word", 32'h0, {16'h0, model.mem[12'h340]});
		chk("program count", 32'h2, model.prog_cnt);
		wr(OFS_CTRL1, 8'h04);
		wr(OFS_ADRL, 8'h40);
		wr(OFS_D0L, 8'h34);
		wr(OFS_D0H, 8'h12);
		wr(OFS_CTRL1, 8'h02);
		poll(8'h02, el);
		chk("rewrite", 32'h1234, {16'h0, model.mem[12'h340]});
		chk("program count", 32'h3, model.prog_cnt);
		$display("test write done");
	endtask : t_write
	task automatic t_read;
		int el;
		wr(OFS_CTRL0, 8'h01);
		rdc("flag cleared", OFS_CTRL0, 32'h01);
		wr(OFS_CTRL1, 8'h02);
		rdc("erase refused", OFS_CTRL1, 32'h0);
		chk("erase count", 32'h2, model.erase_cnt);
		wr(OFS_ADRL, 8'h5e);
		wr(OFS_CTRL0, 8'h03);
		wr(OFS_CTRL1, 8'h01);
		rdc("read without permit", OFS_CTRL1, 32'h0);
		chk("read count", 32'h0, model.rd_cnt);
		wr(OFS_CTRL0, 8'h0b);
		wr(OFS_CTRL1, 8'h01);
		poll(8'h01, el);
		chk("fetch time", 32'h1, {31'h0, el >= FW && el <= FW + 6});
		rdc("fetched low", OFS_D0L, 32'h10);
		rdc("fetched high", OFS_D0H, 32'ha0);
		$display("test read done");
	endtask : t_read

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim

	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		$display("watchdog expired");
		end_sim();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = '0;
		htrans = '0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		unlock(8'h41, 8'h00);
		unlock(8'h40, 8'h20);
		t_erase(8'h00, PS);
		t_erase(8'h01, PL);
		t_write();
		t_read();
		end_sim();
	end
endmodule : fis_top_test
`default_nettype wire
